// >>> hdl/apsc_pkg.sv
// shared constants for the amplifier power sequence control block
package apsc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int ENABLE_DELAY_US = 200;
    localparam int CLK_MHZ         = 100;
    localparam int ENABLE_DELAY_CYC = ENABLE_DELAY_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          APB_AW       = 8;
    localparam logic [7:0]  CTRL_OFFS    = 8'h00;
    localparam logic [7:0]  STATUS_OFFS  = 8'h04;

    localparam int CTRL_FORCE_HIZ_BIT = 0;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

    localparam int ST_STATE_LSB      = 0;
    localparam int ST_STATE_W        = 2;
    localparam int ST_FAULT_BIT      = 2;
    localparam int ST_LOGIC_OK_BIT   = 3;
    localparam int ST_RAIL_OK_BIT    = 4;
    localparam int ST_ANALOG_OK_BIT  = 5;
    localparam int ST_BRIDGE_BIT     = 6;
    localparam int ST_WARN_BIT       = 7;
    localparam int ST_SHARED_ERR_BIT = 8;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        APSC_SLEEP,
        APSC_MUTED,
        APSC_DELAY,
        APSC_ACTIVE
    } apsc_state_e;

endpackage : apsc_pkg

// >>> hdl/apsc_delay_timer.sv
// enable delay counter for the power sequence control block
`timescale 1ns/1ns
`default_nettype none

module apsc_delay_timer #(
    parameter int DELAY_CYC = apsc_pkg::ENABLE_DELAY_CYC
) (
    input  wire logic clk,     // 100 MHz clock
    input  wire logic rst,     // async reset, active high
    input  wire logic start,   // restart count from zero
    input  wire logic cancel,  // abort a running count
    output logic      done     // one-cycle pulse at end of delay
);
    import apsc_pkg::*;

    localparam int CW = $clog2(DELAY_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);
    localparam logic [CW-1:0] ZERO = '0;

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          running;
    logic          next_running;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_comb
    begin
        next_count   = count;
        next_running = running;
        if (start)
        begin
            next_count   = ZERO;
            next_running = 1'b1;
        end
        else if (cancel)
        begin
            next_running = 1'b0;
        end
        else if (running)
        begin
            if (count == LAST)
                next_running = 1'b0;
            else
                next_count = count + CW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count   <= ZERO;
            running <= 1'b0;
        end
        else
        begin
            count   <= next_count;
            running <= next_running;
        end
    end

    // kept free of start and cancel: both are decoded from the next state,
    // which itself depends on done, and would close a combinational loop
    assign done = running && (count == LAST);

    a_done_after_run: assert property (@(posedge clk) disable iff (rst)
        done |-> $past(running))
        else $error("delay done without a running count");

endmodule : apsc_delay_timer
`default_nettype wire

// >>> hdl/apsc_power_seq.sv
// power sequence control for a stereo switching audio output bridge
//
// Functional notes
// - bridge stays high impedance after power-up
// - bridge enables 200 us after mute rises
// - either supply low keeps bridge disabled
// - analog supply never blocks enabling
// - any fault shuts bridge down immediately
// - sleep low means sleep, bridge hi-z
// - mute high runs bridge, low disables
// - faults latched, cleared by mute low-high
// - fault and warning are open-drain, active low
`timescale 1ns/1ns
`default_nettype none

module apsc_power_seq #(
    parameter int DELAY_CYC = apsc_pkg::ENABLE_DELAY_CYC
) (
    input  wire logic                        clk,                      // 100 MHz clock
    input  wire logic                        rst,                      // async reset
    // control pins
    input  wire logic                        sleep_release_n,          // low = sleep
    input  wire logic                        mute_n,                   // low = muted
    // supply and protection status
    input  wire logic                        logic_supply_ok,          // logic uvlo ok
    input  wire logic                        power_rail_supply_ok,     // rail uvlo ok
    input  wire logic                        analog_reference_supply_ok, // status only
    input  wire logic                        fault_event,              // overtemp/overcurrent
    input  wire logic                        thermal_warn,             // warning level
    // bridge control
    output logic                             bridge_enable,            // 1 = follow modulation
    output logic                             logic_awake,              // internal logic awake
    // open-drain flags
    input  wire logic                        fault_flag_n_i,           // shared line level
    output logic                             fault_flag_n_o,           // driven value
    output logic                             fault_flag_n_oe_n,        // low = pull low
    input  wire logic                        thermal_warning_flag_n_i, // shared line level
    output logic                             thermal_warning_flag_n_o, // driven value
    output logic                             thermal_warning_flag_n_oe_n, // low = pull low
    // apb slave
    input  wire logic                        psel,                     // select
    input  wire logic                        penable,                  // access phase
    input  wire logic                        pwrite,                   // 1 = write
    input  wire logic [apsc_pkg::APB_AW-1:0] paddr,                    // byte address
    input  wire logic [31:0]                 pwdata,                   // write data
    output logic [31:0]                      prdata,                   // read data
    output logic                             pready,                   // ready
    output logic                             pslverr                   // unmapped address
);
    import apsc_pkg::*;

    apsc_state_e state;
    apsc_state_e next_state;
    logic        fault_latched;
    logic        next_fault_latched;
    logic        mute_q;
    logic        bridge_q;
    logic        next_bridge;
    logic        force_hiz;
    logic        next_force_hiz;
    logic [31:0] rdata_q;
    logic [31:0] next_rdata;
    logic        err_q;
    logic        next_err;

    logic supplies_ok;
    logic mute_rise;
    logic fault_now;
    logic tmr_start;
    logic tmr_cancel;
    logic tmr_done;

    // ----------------------------------------------------------------
    // fault latch
    // ----------------------------------------------------------------
    // only logic and rail are watched; the analog reference is not
    assign supplies_ok = logic_supply_ok && power_rail_supply_ok;
    assign mute_rise   = mute_n && !mute_q;
    // rail loss while awake is latched like a protection event
    assign fault_now   = fault_event || (logic_awake && !power_rail_supply_ok);

    always_comb
    begin
        next_fault_latched = fault_latched;
        if (mute_rise)
            next_fault_latched = 1'b0;
        if (fault_now)
            next_fault_latched = 1'b1;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    assign tmr_start  = (state == APSC_MUTED) && (next_state == APSC_DELAY);
    assign tmr_cancel = (state == APSC_DELAY) && (next_state != APSC_DELAY);

    always_comb
    begin
        next_state = state;
        case (state)
            APSC_SLEEP:
            begin
                if (sleep_release_n && logic_supply_ok)
                    next_state = APSC_MUTED;
            end
            APSC_MUTED:
            begin
                // clear latch needs a mute low-high, so wait one cycle
                if (mute_n && !fault_latched && !fault_now && supplies_ok
                    && !force_hiz)
                    next_state = APSC_DELAY;
            end
            APSC_DELAY:
            begin
                if (!mute_n || fault_now || !supplies_ok || force_hiz)
                    next_state = APSC_MUTED;
                else if (tmr_done)
                    next_state = APSC_ACTIVE;
            end
            APSC_ACTIVE:
            begin
                if (!mute_n || fault_now || !supplies_ok || force_hiz)
                    next_state = APSC_MUTED;
            end
            default:
                next_state = APSC_SLEEP;
        endcase
        if (!sleep_release_n || !logic_supply_ok)
            next_state = APSC_SLEEP;
    end

    assign next_bridge = (next_state == APSC_ACTIVE);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state         <= APSC_SLEEP;
            fault_latched <= 1'b0;
            mute_q        <= 1'b0;
            bridge_q      <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            fault_latched <= next_fault_latched;
            mute_q        <= mute_n;
            bridge_q      <= next_bridge;
        end
    end

    apsc_delay_timer #(
        .DELAY_CYC (DELAY_CYC)
    ) u_delay (
        .clk    (clk),
        .rst    (rst),
        .start  (tmr_start),
        .cancel (tmr_cancel),
        .done   (tmr_done)
    );

    assign bridge_enable = bridge_q;
    assign logic_awake   = (state != APSC_SLEEP);

    // ----------------------------------------------------------------
    // open-drain flags
    // ----------------------------------------------------------------
    // pull low only; several devices may share each line
    assign fault_flag_n_o              = 1'b0;
    assign fault_flag_n_oe_n           = !fault_latched;
    assign thermal_warning_flag_n_o    = 1'b0;
    assign thermal_warning_flag_n_oe_n = !thermal_warn;

    // ----------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------
    // read data captured in setup so it comes from a flop; no wait states
    always_comb
    begin
        next_rdata     = rdata_q;
        next_err       = err_q;
        next_force_hiz = force_hiz;
        if (psel && !penable)
        begin
            next_rdata = 32'h0000_0000;
            next_err   = 1'b0;
            if (paddr == CTRL_OFFS)
                next_rdata[CTRL_FORCE_HIZ_BIT] = force_hiz;
            else if (paddr == STATUS_OFFS)
            begin
                next_rdata[ST_STATE_LSB +: ST_STATE_W] = state;
                next_rdata[ST_FAULT_BIT]      = fault_latched;
                next_rdata[ST_LOGIC_OK_BIT]   = logic_supply_ok;
                next_rdata[ST_RAIL_OK_BIT]    = power_rail_supply_ok;
                next_rdata[ST_ANALOG_OK_BIT]  = analog_reference_supply_ok;
                next_rdata[ST_BRIDGE_BIT]     = bridge_q;
                next_rdata[ST_WARN_BIT]       = !thermal_warning_flag_n_i;
                next_rdata[ST_SHARED_ERR_BIT] = !fault_flag_n_i;
            end
            else
                next_err = 1'b1;
        end
        if (psel && penable && pwrite && paddr == CTRL_OFFS)
            next_force_hiz = pwdata[CTRL_FORCE_HIZ_BIT];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q   <= 32'h0000_0000;
            err_q     <= 1'b0;
            force_hiz <= CTRL_RESET[CTRL_FORCE_HIZ_BIT];
        end
        else
        begin
            rdata_q   <= next_rdata;
            err_q     <= next_err;
            force_hiz <= next_force_hiz;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && err_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // cycles spent waiting; the delay is far too long for a repetition
    logic [31:0] delay_cycles;
    logic [31:0] next_delay_cycles;

    always_comb
    begin
        next_delay_cycles = 32'h0000_0000;
        if (state == APSC_DELAY)
            next_delay_cycles = delay_cycles + 32'h0000_0001;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            delay_cycles <= 32'h0000_0000;
        else
            delay_cycles <= next_delay_cycles;
    end

    a_delay_full: assert property (@(posedge clk) disable iff (rst)
        $rose(bridge_enable) |-> delay_cycles == 32'(DELAY_CYC))
        else $error("bridge enabled before the full delay");

    a_wake_muted: assert property (@(posedge clk) disable iff (rst)
        (state == APSC_SLEEP) && sleep_release_n && logic_supply_ok
        |=> (state == APSC_MUTED) && !bridge_enable)
        else $error("wake did not stop in the muted state");

    a_fault_clear: assert property (@(posedge clk) disable iff (rst)
        fault_latched && mute_rise && !fault_now |=> !fault_latched)
        else $error("fault latch not cleared by mute toggle");

    a_reset_hiz: assert property (@(posedge clk)
        $fell(rst) |-> !bridge_enable)
        else $error("bridge enabled right after reset");

    a_delay_len: assert property (@(posedge clk) disable iff (rst)
        $rose(bridge_enable) |-> $past(state == APSC_DELAY, 2))
        else $error("bridge enabled without the delay state");

    a_delay_min: assert property (@(posedge clk) disable iff (rst)
        (state == APSC_MUTED) ##1 (state == APSC_DELAY) |->
        !bridge_enable [*8])
        else $error("bridge enabled too soon after mute rise");

    a_supply_off: assert property (@(posedge clk) disable iff (rst)
        (!logic_supply_ok || !power_rail_supply_ok) |=> !bridge_enable)
        else $error("bridge on with a supply missing");

    a_fault_off: assert property (@(posedge clk) disable iff (rst)
        fault_event |=> !bridge_enable && fault_latched)
        else $error("bridge not shut down on fault");

    a_fault_hold: assert property (@(posedge clk) disable iff (rst)
        fault_latched && !mute_rise |=> fault_latched)
        else $error("fault latch cleared without mute toggle");

    a_sleep_hiz: assert property (@(posedge clk) disable iff (rst)
        !sleep_release_n |=> !bridge_enable && !logic_awake)
        else $error("bridge or logic on while asleep");

    a_mute_off: assert property (@(posedge clk) disable iff (rst)
        !mute_n |=> !bridge_enable)
        else $error("bridge on while muted");

    a_flag_drive: assert property (@(posedge clk) disable iff (rst)
        fault_latched |-> !fault_flag_n_oe_n && !fault_flag_n_o)
        else $error("fault line not pulled low");

    a_analog_free: assert property (@(posedge clk) disable iff (rst)
        (state == APSC_DELAY) && tmr_done && mute_n && !fault_now && supplies_ok
        && !force_hiz && sleep_release_n |=> bridge_enable)
        else $error("bridge blocked despite conditions met");

endmodule : apsc_power_seq
`default_nettype wire

// >>> sim/apsc_host_model.sv
// controller and modulator model driving the sleep and mute pins
`timescale 1ns/1ns
`default_nettype none

module apsc_host_model (
    input  wire logic clk,             // 100 MHz clock
    input  wire logic fault_line_n,    // resolved shared fault line
    output var logic  sleep_release_n, // low = device asleep
    output var logic  mute_n,          // low = bridge muted
    output var logic  mod_run          // modulator sending pulses
);
    logic line_q;

    // ----------------------------------------------------------------
    // power-up state
    // ----------------------------------------------------------------
    initial
    begin
        sleep_release_n = 1'b0;
        mute_n          = 1'b0;
        mod_run         = 1'b0;
        line_q          = 1'b1;
    end

    // only a falling line mutes, so a later unmute is not undone at once
    always @(posedge clk)
    begin
        line_q <= fault_line_n;
        if (line_q && !fault_line_n)
        begin
            mute_n  <= 1'b0;
            mod_run <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    task automatic wake();
        @(posedge clk);
        sleep_release_n <= 1'b1;
    endtask : wake

    // modulator starts on the same edge as mute; mute only rises once awake
    task automatic unmute();
        @(posedge clk);
        mod_run <= 1'b1;
        if (sleep_release_n)
            mute_n <= 1'b1;
    endtask : unmute

    task automatic mute();
        @(posedge clk);
        mute_n  <= 1'b0;
        mod_run <= 1'b0;
    endtask : mute

    task automatic sleep();
        if (mute_n)
            mute();
        @(posedge clk);
        sleep_release_n <= 1'b0;
    endtask : sleep
endmodule : apsc_host_model

`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the power sequence control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))

module testbench;
    import apsc_pkg::*;
    localparam int D = 16;
    logic clk = 1'b0, rst = 1'b1, lsup = 1'b1, rsup = 1'b1, asup = 1'b1;
    logic flt = 1'b0, warn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, bridge, awake, sleep_n, mute_n, f_o, f_oe_n, w_o, w_oe_n;
    wire  f_line = f_oe_n ? 1'b1 : f_o; // pull-up on open drain
    wire  w_line = w_oe_n ? 1'b1 : w_o;
    int   error_cnt = 0, comparisons = 0, n;

    always #5 clk = ~clk;

    apsc_power_seq #(.DELAY_CYC(D)) uut (.clk(clk), .rst(rst), .sleep_release_n(sleep_n),
        .mute_n(mute_n), .logic_supply_ok(lsup), .power_rail_supply_ok(rsup),
        .analog_reference_supply_ok(asup), .fault_event(flt), .thermal_warn(warn),
        .bridge_enable(bridge), .logic_awake(awake), .fault_flag_n_i(f_line),
        .fault_flag_n_o(f_o), .fault_flag_n_oe_n(f_oe_n), .thermal_warning_flag_n_i(w_line),
        .thermal_warning_flag_n_o(w_o), .thermal_warning_flag_n_oe_n(w_oe_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    apsc_host_model host (.clk(clk), .fault_line_n(f_line), .sleep_release_n(sleep_n),
        .mute_n(mute_n), .mod_run());

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            error_cnt++;
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            error_cnt++;
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_bridge();
        n = 0;
        while (bridge !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_bridge

    function automatic logic [31:0] st(logic [1:0] s, logic f, logic a, logic b);
        return 32'(s) | (32'(f) << ST_FAULT_BIT) | (32'h1 << ST_LOGIC_OK_BIT)
            | (32'h1 << ST_RAIL_OK_BIT) | (32'(a) << ST_ANALOG_OK_BIT)
            | (32'(b) << ST_BRIDGE_BIT) | (32'(f) << ST_SHARED_ERR_BIT);
    endfunction : st

    task automatic results();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK({bridge, awake, f_oe_n}, 3'b001);
        apb(1'b0, STATUS_OFFS, 32'h0);
        `CHK(rd, st(2'd0, 1'b0, 1'b1, 1'b0));
        apb(1'b1, STATUS_OFFS, 32'hffff_ffff);
        apb(1'b0, STATUS_OFFS, 32'h0);
        `CHK(rd, st(2'd0, 1'b0, 1'b1, 1'b0));
        apb(1'b0, 8'h08, 32'h0);
        `CHK(err, 1'b1);
        `CHK(rd, 32'h0);
        host.wake();
        repeat (30) @(posedge clk);
        `CHK({awake, bridge}, 2'b10);
        asup <= 1'b0; // analog low must not block
        host.unmute();
        wait_bridge();
        `CHK(n, D + 1);
        apb(1'b0, STATUS_OFFS, 32'h0);
        `CHK(rd, st(2'd3, 1'b0, 1'b0, 1'b1));
        asup <= 1'b1;
        host.mute();
        @(posedge clk);
        #1;
        `CHK(bridge, 1'b0);
        host.unmute();
        repeat (10) @(posedge clk);
        host.mute();
        repeat (2) @(posedge clk);
        host.unmute();
        wait_bridge();
        `CHK(n, D + 1);
        // supplies recover before any unmute
        rsup <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1;
        `CHK(bridge, 1'b0);
        repeat (40) @(posedge clk);
        `CHK(bridge, 1'b0);
        rsup <= 1'b1;
        host.mute();
        host.unmute();
        wait_bridge();
        `CHK(bridge, 1'b1);
        host.mute();
        lsup <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1;
        `CHK({bridge, awake}, 2'b00);
        lsup <= 1'b1;
        host.wake();
        host.unmute();
        wait_bridge();
        `CHK(n, D + 1);
        warn <= 1'b1;
        @(posedge clk);
        #1;
        `CHK({w_oe_n, bridge}, 2'b01);
        warn <= 1'b0;
        flt  <= 1'b1;
        @(posedge clk);
        flt  <= 1'b0;
        #1;
        `CHK({bridge, f_oe_n, f_line}, 3'b000);
        repeat (20) @(posedge clk);
        apb(1'b0, STATUS_OFFS, 32'h0);
        `CHK(rd, st(2'd1, 1'b1, 1'b1, 1'b0));
        `CHK({mute_n, f_oe_n}, 2'b00);
        host.unmute();
        wait_bridge();
        `CHK(n, D + 2);
        `CHK(f_oe_n, 1'b1);
        apb(1'b1, CTRL_OFFS, 32'h1);
        @(posedge clk);
        #1;
        `CHK(bridge, 1'b0);
        apb(1'b0, CTRL_OFFS, 32'h0);
        `CHK(err, 1'b0);
        `CHK(rd, 32'h1);
        apb(1'b1, CTRL_OFFS, 32'h0);
        host.mute();
        host.unmute();
        wait_bridge();
        `CHK(n, D + 1);
        host.sleep();
        @(posedge clk);
        @(posedge clk);
        #1;
        `CHK({bridge, awake}, 2'b00);
        rsup <= 1'b0;
        @(posedge clk);
        lsup <= 1'b0;
        @(posedge clk);
        asup <= 1'b0;
        results();
    end

    initial
    begin
        #200000;
        error_cnt++;
        results();
    end
endmodule : testbench

`default_nettype wire
